// file: rtl/access_arbiter.sv
`default_nettype none
// ==========================================================
// bus side wins the storage; the engine waits one cycle at most per bus access
module access_arbiter
   import can_buf_pkg::*;
(
   input  wire logic        apbReq,
   input  wire logic        apbWe,
   input  wire logic [7:0]  apbAddr,
   input  wire logic [1:0]  apbBe,
   input  wire logic [15:0] apbWdata,
   input  wire logic        engValid,
   input  wire logic        engWrite,
   input  wire logic [7:0]  engAddr,
   input  wire logic [1:0]  engBe,
   input  wire logic [15:0] engWdata,
   output logic             engGrant,
   buf_mem_if.ctrl          port
);
   // fixed priority select
   always_comb begin
      engGrant   = engValid && !apbReq;
      port.en    = apbReq || engValid;
      port.we    = apbReq ? apbWe    : engWrite;
      port.addr  = apbReq ? apbAddr  : engAddr;
      port.be    = apbReq ? apbBe    : engBe;
      port.wdata = apbReq ? apbWdata : engWdata;
   end
endmodule
`default_nettype wire

// file: rtl/buf_mem_if.sv
`default_nettype none
// ==========================================================
// single-port path into the buffer storage
interface buf_mem_if;
   logic        en;
   logic        we;
   logic [7:0]  addr;
   logic [1:0]  be;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport ctrl (output en, output we, output addr, output be, output wdata, input rdata);
   modport mem  (input en, input we, input addr, input be, input wdata, output rdata);
endinterface
`default_nettype wire

// file: rtl/buffer_ram.sv
`default_nettype none
// ==========================================================
// byte-lane storage, contents undefined after power-up
module buffer_ram
   import can_buf_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   buf_mem_if.mem   port
);
   // one lane per byte so the pair halves write independently
   for (genvar g = 0; g < 2; g++) begin : gLane
      logic [7:0] laneMem [MEM_WORDS];
      logic [7:0] laneRd;
      always_ff @(posedge clock) begin
         if (port.en && port.we && port.be[g]) begin
            laneMem[port.addr] <= port.wdata[g*8 +: 8];
         end
      end
      // each lane owns its read register, so no variable has two writers
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            laneRd <= RAM_RESET[g*8 +: 8];
         end else if (port.en && !port.we) begin
            laneRd <= laneMem[port.addr];
         end
      end
   end

   assign port.rdata = {gLane[1].laneRd, gLane[0].laneRd};

   chk_ram_range : assert property (@(posedge clock) disable iff (reset)
      port.en |-> (32'(port.addr) < MEM_WORDS))
      else $error("buffer storage address out of range");
endmodule
`default_nettype wire

// file: rtl/can_buf_pkg.sv
`default_nettype none
package can_buf_pkg;
   // ==========================================================
   // storage geometry
   localparam int unsigned BUFFER_COUNT     = 32;
   localparam int unsigned DATA_BYTES       = 8;
   localparam int unsigned WORDS_PER_BUFFER = 5;   // length word plus four byte pairs
   localparam int unsigned MEM_WORDS        = BUFFER_COUNT * WORDS_PER_BUFFER;
   localparam int unsigned MEM_AW           = 8;
   localparam int unsigned ADDR_W           = 12;

   // ==========================================================
   // length-control word layout
   localparam int unsigned EXT_ID_MSB   = 15;
   localparam int unsigned EXT_ID_LSB   = 10;
   localparam int unsigned REMOTE_BIT   = 9;
   localparam int unsigned RES_HI_BIT   = 8;
   localparam int unsigned UNIMPL_MSB   = 7;
   localparam int unsigned UNIMPL_LSB   = 5;
   localparam int unsigned RES_LO_BIT   = 4;
   localparam int unsigned DLC_MSB      = 3;
   localparam logic [15:0] LEN_KEEP_MASK = 16'hff1f;  // bits 7..5 never stored
   localparam logic [15:0] FULL_MASK     = 16'hffff;

   // ==========================================================
   // apb map: one 0x20 slot per buffer, words at 0x00 .. 0x10
   localparam logic [ADDR_W-1:0] LEN_WORD_OFFSET  = 12'h000;
   localparam logic [ADDR_W-1:0] DATA_WORD_OFFSET = 12'h004;  // pair k at 0x04 + 4k
   localparam logic [ADDR_W-1:0] BUFFER_STRIDE    = 12'h020;
   localparam logic [ADDR_W-1:0] MAP_LIMIT        = 12'h400;
   localparam logic [2:0]        LEN_WORD_INDEX   = 3'h0;
   localparam logic [2:0]        LAST_WORD_INDEX  = 3'h4;

   // ==========================================================
   // reset values and timing
   localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;
   localparam logic [15:0] RAM_RESET    = 16'h0000;
   localparam int unsigned READ_LATENCY = 2;  // access-phase edges before pready

   typedef enum logic [1:0] {
      APB_IDLE    = 2'b00,
      APB_WAIT_RD = 2'b01,
      APB_RESPOND = 2'b11
   } apb_state_e;
endpackage
`default_nettype wire

// file: rtl/can_message_buffers.sv
`default_nettype none
module can_message_buffers
   import can_buf_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              reset,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // protocol engine port
   input  wire logic              engReq,
   input  wire logic              engWrite,
   input  wire logic [4:0]        engBuffer,
   input  wire logic [2:0]        engWord,
   input  wire logic [15:0]       engWdata,
   input  wire logic [1:0]        engByteEn,
   output logic                   engGrant,
   output logic                   engRvalid,
   output logic [15:0]            engRdata,
   output logic [5:0]             engExtIdLow,
   output logic                   engRemote,
   output logic [3:0]             engDlc
);
   // ==========================================================
   // state
   typedef struct packed {
      apb_state_e  state;
      logic [31:0] rdata;
      logic        err;
      logic        engRd;
   } state_s;

   state_s cur;
   state_s next_cur;

   buf_mem_if memBus ();

   logic        access;
   logic        mapped;
   logic [2:0]  apbWord;
   logic [4:0]  apbBuffer;
   logic        apbIsLen;
   logic        apbReq;
   logic        apbWe;
   logic [15:0] apbWdata;
   logic [15:0] apbMask;
   logic        engValid;
   logic [15:0] engMask;
   logic [15:0] engWmasked;

   // buffer n, word w sits at storage row 5n + w
   function automatic logic [7:0] rowOf(input logic [4:0] b, input logic [2:0] w);
      logic [7:0] r;
      r = 8'(8'(b) * 8'(WORDS_PER_BUFFER)) + 8'(w);
      return r;
   endfunction

   // ==========================================================
   // address decode
   always_comb begin
      access    = psel && penable;
      apbWord   = paddr[4:2];
      apbBuffer = paddr[9:5];
      apbIsLen  = (apbWord == LEN_WORD_INDEX);
      if (paddr >= MAP_LIMIT) begin
         mapped = 1'b0;
      end else if (apbWord > LAST_WORD_INDEX) begin
         mapped = 1'b0;                           // holes 0x14..0x1c of each slot
      end else begin
         mapped = 1'b1;
      end
      apbMask  = apbIsLen ? LEN_KEEP_MASK : FULL_MASK;
      apbWdata = pwdata[15:0] & apbMask;
   end

   // ==========================================================
   // engine request shaping; same masking as the bus side
   always_comb begin
      engValid   = engReq && (engWord <= LAST_WORD_INDEX);
      engMask    = (engWord == LEN_WORD_INDEX) ? LEN_KEEP_MASK : FULL_MASK;
      engWmasked = engWdata & engMask;
   end

   // ==========================================================
   // bus state machine; a write commits on the edge pready is seen
   always_comb begin
      next_cur       = cur;
      apbReq         = 1'b0;
      apbWe          = 1'b0;
      case (cur.state)
         APB_IDLE: begin
            if (access) begin
               if (!mapped) begin
                  next_cur.state = APB_RESPOND;
                  next_cur.err   = 1'b1;
                  next_cur.rdata = RDATA_RESET;
               end else if (pwrite) begin
                  next_cur.state = APB_RESPOND;
                  next_cur.err   = 1'b0;
                  next_cur.rdata = RDATA_RESET;
               end else if (!engValid) begin
                  // engine keeps the storage; the bus read waits in APB_IDLE for as long as engValid holds
                  apbReq         = 1'b1;
                  next_cur.state = APB_WAIT_RD;
                  next_cur.err   = 1'b0;
               end
            end
         end
         APB_WAIT_RD: begin
            next_cur.rdata = {16'h0000, memBus.rdata & apbMask};
            next_cur.state = APB_RESPOND;
         end
         APB_RESPOND: begin
            if (pwrite && !cur.err) begin
               apbReq = 1'b1;
               apbWe  = 1'b1;
            end
            next_cur.state = APB_IDLE;
            next_cur.err   = 1'b0;
         end
         default: begin
            next_cur.state = APB_IDLE;
         end
      endcase
      // taken from the request, not the arbiter output, so no loop through the arbiter
      next_cur.engRd = engValid && !apbReq && !engWrite;
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cur.state <= APB_IDLE;
         cur.rdata <= RDATA_RESET;
         cur.err   <= 1'b0;
         cur.engRd <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   // ==========================================================
   // storage and its arbiter
   access_arbiter uArb (
      .apbReq   (apbReq),
      .apbWe    (apbWe),
      .apbAddr  (rowOf(apbBuffer, apbWord)),
      .apbBe    (pstrb[1:0]),
      .apbWdata (apbWdata),
      .engValid (engValid),
      .engWrite (engWrite),
      .engAddr  (rowOf(engBuffer, engWord)),
      .engBe    (engByteEn),
      .engWdata (engWmasked),
      .engGrant (engGrant),
      .port     (memBus.ctrl)
   );

   buffer_ram uRam (
      .clock (clock),
      .reset (reset),
      .port  (memBus.mem)
   );

   // ==========================================================
   // outputs; engine fields are slices of the registered read word
   assign prdata      = cur.rdata;
   assign pready      = (cur.state == APB_RESPOND);
   assign pslverr     = pready && cur.err;
   assign engRvalid   = cur.engRd;
   assign engRdata    = memBus.rdata;
   assign engExtIdLow = memBus.rdata[EXT_ID_MSB:EXT_ID_LSB];
   assign engRemote   = memBus.rdata[REMOTE_BIT];
   assign engDlc      = memBus.rdata[DLC_MSB:0];

   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   chk_len_write_mask : assert property (
      (pready && pwrite && !pslverr && apbIsLen) |->
      (memBus.we && memBus.wdata[UNIMPL_MSB:UNIMPL_LSB] == 3'h0 &&
       memBus.wdata[EXT_ID_MSB:RES_HI_BIT] == pwdata[EXT_ID_MSB:RES_HI_BIT] &&
       memBus.wdata[RES_LO_BIT:0] == pwdata[RES_LO_BIT:0]))
      else $error("length word write not masked");

   chk_len_read_zero : assert property (
      (pready && !pwrite && apbIsLen) |-> (prdata[UNIMPL_MSB:UNIMPL_LSB] == 3'h0))
      else $error("unimplemented length bits read nonzero");

   chk_write_commit : assert property (
      (pready && pwrite && !pslverr) |->
      (memBus.en && memBus.addr == rowOf(apbBuffer, apbWord)))
      else $error("bus write did not reach the addressed row");

   chk_byte_lane_pair : assert property (
      (pready && pwrite && !pslverr && !apbIsLen) |->
      (memBus.be == pstrb[1:0] && memBus.wdata == pwdata[15:0]))
      else $error("byte pair lanes swapped or dropped");

   chk_read_latency : assert property (
      (cur.state == APB_IDLE && access && mapped && !pwrite && !engValid) |->
      ##1 !pready ##1 (pready && !pslverr && prdata[31:16] == 16'h0000))
      else $error("bus read answer not on second edge");

   chk_unmapped_err : assert property (
      (cur.state == APB_IDLE && access && !mapped) |=>
      (pready && pslverr && prdata == RDATA_RESET && !apbWe))
      else $error("unmapped access not refused");

   chk_dlc_field : assert property (
      engRvalid |-> (engDlc == engRdata[DLC_MSB:0] && engRdata == memBus.rdata))
      else $error("length code field mismatch");

   chk_remote_flag : assert property (
      engRvalid |-> (engRemote == engRdata[REMOTE_BIT] &&
                     engExtIdLow == engRdata[EXT_ID_MSB:EXT_ID_LSB]))
      else $error("remote flag or identifier field mismatch");

   chk_engine_grant : assert property (
      (engGrant && !engWrite) |=> engRvalid)
      else $error("engine read without valid");

   // bus and engine never own the storage in the same cycle
   chk_grant_exclusive : assert property (
      !(engGrant && apbReq))
      else $error("bus and engine granted together");

   // words past the last byte pair are never handed to the engine
   chk_engine_refused : assert property (
      (engReq && engWord > LAST_WORD_INDEX) |-> !engGrant)
      else $error("engine granted a word outside the buffer");

   // engine writes to the length word lose bits 7..5 like bus writes
   chk_eng_len_mask : assert property (
      (engGrant && engWrite && engWord == LEN_WORD_INDEX) |->
      (memBus.we && memBus.wdata[UNIMPL_MSB:UNIMPL_LSB] == 3'h0))
      else $error("engine length write not masked");

   // engine lane enables reach the storage unchanged
   chk_eng_lanes : assert property (
      (engGrant && engWrite) |-> (memBus.we && memBus.be == engByteEn))
      else $error("engine byte lanes not passed through");

   // writes answer one edge after they are taken
   chk_write_answer : assert property (
      (cur.state == APB_IDLE && access && mapped && pwrite) |=> (pready && !pslverr))
      else $error("bus write answer not on next edge");

   // the answer stands for one cycle only
   chk_ready_pulse : assert property (
      pready |=> !pready)
      else $error("pready held longer than one cycle");

   // only the low half of the bus word carries storage
   chk_upper_half_zero : assert property (
      pready |-> (prdata[31:16] == 16'h0000))
      else $error("upper half of read data nonzero");

   cov_len_read   : cover property (pready && !pwrite && apbIsLen && !pslverr);
   cov_upper_lane : cover property (pready && pwrite && pstrb[1:0] == 2'b10 && !apbIsLen);
   cov_bus_stall  : cover property (cur.state == APB_IDLE && access && engValid);
   cov_remote_rx  : cover property (engRvalid && engRemote);
   cov_eng_len_wr : cover property (engGrant && engWrite && engWord == LEN_WORD_INDEX);
endmodule
`default_nettype wire

// file: testbench/can_engine_model.sv
`default_nettype none
// ==========================================================
// protocol engine stand-in: one storage access per go pulse
module can_engine_model
   import can_buf_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        go,
   input  wire logic        opWrite,
   input  wire logic [4:0]  opBuffer,
   input  wire logic [2:0]  opWord,
   input  wire logic [15:0] opData,
   input  wire logic [1:0]  opLanes,
   input  wire logic        engGrant,
   input  wire logic        engRvalid,
   input  wire logic [15:0] engRdata,
   output logic             engReq,
   output logic             engWrite,
   output logic [4:0]       engBuffer,
   output logic [2:0]       engWord,
   output logic [15:0]      engWdata,
   output logic [1:0]       engByteEn,
   output logic             done,
   output logic [15:0]      result
);
   timeunit 1ns;
   timeprecision 100ps;
   // request held until the grant edge; released data lines carry junk, not stale values
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         engReq    <= 1'b0;
         engWrite  <= 1'b0;
         engBuffer <= 5'h00;
         engWord   <= 3'h0;
         engWdata  <= 16'h0000;
         engByteEn <= 2'h0;
         done      <= 1'b0;
         result    <= 16'h0000;
      end else begin
         done <= 1'b0;
         if (engReq && engGrant) begin
            engReq   <= 1'b0;
            engWdata <= ~engWdata;
            done     <= engWrite;
         end else if (go && !engReq) begin
            engReq    <= 1'b1;
            engWrite  <= opWrite;
            engBuffer <= opBuffer;
            engWord   <= opWord;
            engWdata  <= opData;
            engByteEn <= opLanes;
         end
         if (engRvalid) begin
            result <= engRdata;
            done   <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: testbench/tb_can_message_buffers.sv
`default_nettype none
module tb_can_message_buffers
   import can_buf_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic              clock, reset, psel, penable, pwrite, pready, pslverr, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [3:0]        pstrb, engDlc;
   logic              engReq, engWrite, engGrant, engRvalid, engRemote, go, opWrite, done;
   logic [4:0]        engBuffer, opBuffer;
   logic [2:0]        engWord, opWord;
   logic [15:0]       engWdata, engRdata, opData, result;
   logic [1:0]        engByteEn, opLanes;
   logic [5:0]        engExtIdLow;
   int                n_errors, check_count, k;
   localparam logic [ADDR_W-1:0] BAD[5] = '{12'h014, 12'h018, 12'h01c, 12'h400, 12'hffc};

   can_message_buffers u_can_message_buffers (.clock, .reset, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .engReq, .engWrite, .engBuffer,
      .engWord, .engWdata, .engByteEn, .engGrant, .engRvalid, .engRdata, .engExtIdLow,
      .engRemote, .engDlc);
   can_engine_model u_can_engine_model (.clock, .reset, .go, .opWrite, .opBuffer, .opWord,
      .opData, .opLanes, .engGrant, .engRvalid, .engRdata, .engReq, .engWrite, .engBuffer,
      .engWord, .engWdata, .engByteEn, .done, .result);

   // ==========================================================
   // clock, 25 ns period
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // ==========================================================
   // compare and report
   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check1(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic timeout(input int i);
      if (i >= 20) begin
         n_errors++;
         $display("ERROR at %0t: no answer", $time);
         finish_test();
      end
   endtask

   // ==========================================================
   // apb transfer: held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d,
                      input logic [3:0] s);
      int i;
      @(posedge clock);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {16'h0000, d};
      pstrb   <= s;
      @(posedge clock);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      timeout(i);
   endtask

   // engine access through the partner model
   task automatic eng(input logic w, input logic [4:0] b, input logic [2:0] n,
                      input logic [15:0] d, input logic [1:0] l);
      int i;
      @(posedge clock);
      go       <= 1'b1;
      opWrite  <= w;
      opBuffer <= b;
      opWord   <= n;
      opData   <= d;
      opLanes  <= l;
      @(posedge clock);
      go <= 1'b0;
      for (i = 0; i < 20; i++) begin
         @(posedge clock);
         if (done === 1'b1) break;
      end
      timeout(i);
   endtask

   // ==========================================================
   // main sequence; every field is written before the engine reads it
   initial begin
      {reset, psel, penable, pwrite, go, opWrite} = 6'b100000;
      {paddr, pwdata, pstrb, opBuffer, opWord, opData, opLanes} = '0;
      n_errors = 0;
      check_count = 0;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      apb(1'b1, 12'h000, 16'hfeef, 4'h3);
      check1(err, 1'b0);
      apb(1'b0, 12'h000, 16'h0000, 4'h3);
      check16(rd[15:0], 16'hfe0f);
      check16(rd[31:16], 16'h0000);
      apb(1'b1, 12'h3e0, 16'h2805, 4'h3);
      eng(1'b0, 5'd0, 3'd0, 16'h0000, 2'h3);
      check16({5'h00, engExtIdLow, engRemote, engDlc}, {5'h00, 6'h3f, 1'b1, 4'hf});
      eng(1'b0, 5'd31, 3'd0, 16'h0000, 2'h3);
      check16({5'h00, engExtIdLow, engRemote, engDlc}, {5'h00, 6'h0a, 1'b0, 4'h5});
      // data pairs of buffer 5, byte m holds 0x30 + m
      for (k = 0; k < 4; k++) begin
         apb(1'b1, 12'h0a4 + 12'(4 * k), {8'h31 + 8'(2 * k), 8'h30 + 8'(2 * k)}, 4'h3);
      end
      for (k = 0; k < 4; k++) begin
         apb(1'b0, 12'h0a4 + 12'(4 * k), 16'h0000, 4'h3);
         check16(rd[15:0], {8'h31 + 8'(2 * k), 8'h30 + 8'(2 * k)});
         eng(1'b0, 5'd5, 3'(k + 1), 16'h0000, 2'h3);
         check16(result, {8'h31 + 8'(2 * k), 8'h30 + 8'(2 * k)});
      end
      // low lane only: the odd byte must survive
      apb(1'b1, 12'h0a4, 16'haa55, 4'h1);
      apb(1'b0, 12'h0a4, 16'h0000, 4'h3);
      check16(rd[15:0], 16'h3155);
      // high lane only: the even byte must survive
      apb(1'b1, 12'h0b0, 16'h99aa, 4'h2);
      apb(1'b0, 12'h0b0, 16'h0000, 4'h3);
      check16(rd[15:0], 16'h9936);
      eng(1'b1, 5'd31, 3'd4, 16'hbeef, 2'h3);
      apb(1'b0, 12'h3f0, 16'h0000, 4'h3);
      check16(rd[15:0], 16'hbeef);
      // engine writes the low lane only: the high byte stays
      eng(1'b1, 5'd31, 3'd4, 16'h1234, 2'h1);
      apb(1'b0, 12'h3f0, 16'h0000, 4'h3);
      check16(rd[15:0], 16'hbe34);
      eng(1'b1, 5'd2, 3'd0, 16'h00e3, 2'h3);
      apb(1'b0, 12'h040, 16'h0000, 4'h3);
      check16(rd[15:0], 16'h0003);
      // unmapped places answer with an error and no data
      foreach (BAD[i]) begin
         apb(1'b0, BAD[i], 16'h0000, 4'h3);
         check1(err, 1'b1);
         check16(rd[15:0], 16'h0000);
      end
      // bus and engine at once: both must complete with correct data
      fork
         apb(1'b0, 12'h000, 16'h0000, 4'h3);
         eng(1'b0, 5'd5, 3'd1, 16'h0000, 2'h3);
      join
      check16(rd[15:0], 16'hfe0f);
      check16(result, 16'h3155);
      finish_test();
   end
endmodule
`default_nettype wire
